// ### rtl/cprt_defines.svh
// Constant definitions for the coprocessor register transfer unit.
`ifndef CPRT_DEFINES_SVH
`define CPRT_DEFINES_SVH
`define CPRT_COND_HI 31
`define CPRT_COND_LO 28
`define CPRT_CLASS_HI 27
`define CPRT_CLASS_LO 24
`define CPRT_CLASS_CRT 4'hE
`define CPRT_CLASS_UND_HI 27
`define CPRT_CLASS_UND_LO 25
`define CPRT_CLASS_UND 3'h3
`define CPRT_UND_BIT 4
`define CPRT_XFER_BIT 4
`define CPRT_DIR_BIT 20
`define CPRT_CRN_HI 19
`define CPRT_CRN_LO 16
`define CPRT_RD_HI 15
`define CPRT_RD_LO 12
`define CPRT_CPN_HI 11
`define CPRT_CPN_LO 8
`define CPRT_PC_REG 4'hF
`define CPRT_PC_OFFSET 32'h0000000C
`define CPRT_FLAG_HI 31
`define CPRT_FLAG_LO 28
`define CPRT_UND_S_CYCLES 2'h2
`endif

// ### rtl/cprt_pkg.sv
// Types shared by the coprocessor register transfer unit.
package cprt_pkg;
    typedef enum logic [2:0] {
        CPRT_IDLE = 3'b000,
        CPRT_SEQ = 3'b001,
        CPRT_BUSY = 3'b010,
        CPRT_INT = 3'b011,
        CPRT_XFER = 3'b100,
        CPRT_UND_S = 3'b101,
        CPRT_UND_I = 3'b110,
        CPRT_UND_N = 3'b111
    } cprt_state_e;
    typedef enum logic [1:0] {
        CPRT_CY_NONE = 2'h0,
        CPRT_CY_S = 2'h1,
        CPRT_CY_I = 2'h2,
        CPRT_CY_C = 2'h3
    } cprt_cycle_e;
endpackage : cprt_pkg

// ### rtl/cprt_cond.sv
// Condition field evaluator against the four status flags.
`timescale 1ns/1ps
module cprt_cond (
    input wire logic [3:0] cond,
    input wire logic [3:0] nzcv,
    output logic pass
);
    logic n, z, c, v;
    // Standard sixteen-way condition table; the last code never passes.
    always_comb begin
        n = nzcv[3];
        z = nzcv[2];
        c = nzcv[1];
        v = nzcv[0];
        case (cond)
            4'h0: pass = z;
            4'h1: pass = !z;
            4'h2: pass = c;
            4'h3: pass = !c;
            4'h4: pass = n;
            4'h5: pass = !n;
            4'h6: pass = v;
            4'h7: pass = !v;
            4'h8: pass = c && !z;
            4'h9: pass = !c || z;
            4'hA: pass = n == v;
            4'hB: pass = n != v;
            4'hC: pass = !z && (n == v);
            4'hD: pass = z || (n != v);
            4'hE: pass = 1'b1;
            default: pass = 1'b0;
        endcase
    end
endmodule : cprt_cond

// ### rtl/cprt_unit.sv
// Core-side sequencer for coprocessor register transfers and the undefined trap.
// Functional notes
// [RULE_01] Execute only when the condition field in bits 31:28 passes.
// [RULE_02] A transfer has 1110 in bits 27:24 and bit 4 set.
// [RULE_03] Coprocessor number 11:8, core register 15:12, coprocessor register 19:16.
// [RULE_04] Bit 20 low moves core to coprocessor, high moves coprocessor to core.
// [RULE_05] Opcode, info and coprocessor register fields belong to the coprocessor.
// [RULE_06] Move-from to the program counter loads only the four flags from 31:28.
// [RULE_07] Move-to from the program counter sends instruction address plus 12.
// [RULE_08] Move-from takes one S, busy plus one I, then one C cycle.
// [RULE_09] Move-to takes one S, busy I cycles, then one C cycle.
// [RULE_10] Each transfer carries exactly one 32-bit word.
// [RULE_11] A passing undefined encoding enters the undefined trap.
// [RULE_12] Coprocessors refuse the undefined encoding with not-present and wait high.
// [RULE_13] Undefined handling takes two S, one I and one N cycle.
// [RULE_14] A transfer no coprocessor accepts takes the undefined trap instead.
`timescale 1ns/1ps
`include "cprt_defines.svh"
module cprt_unit
    import cprt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] instr_addr,
    input wire logic [31:0] core_reg_data,
    input wire logic [3:0] status_flags,
    input wire logic coproc_not_present,
    input wire logic coproc_wait,
    input wire logic [31:0] coproc_rdata,
    output logic busy,
    output logic done,
    output logic [3:0] core_reg_sel,
    output logic coproc_req,
    output logic [3:0] coproc_number_field,
    output logic [31:0] coproc_instr,
    output logic coproc_xfer,
    output logic [31:0] coproc_wdata,
    output logic reg_we,
    output logic [3:0] reg_waddr,
    output logic [31:0] reg_wdata,
    output logic flags_we,
    output logic [3:0] flags_wdata,
    output logic undef_trap,
    output logic [1:0] cycle_type
);
    typedef struct packed {
        cprt_state_e st;
        logic [31:0] ins;
        logic [31:0] pc;
        logic [1:0] cnt; // S cycles spent on the undefined path.
        logic busy;
        logic done;
        logic req;
        logic xfer;
        logic [31:0] wdata;
        logic reg_we;
        logic [31:0] reg_wdata;
        logic flags_we;
        logic [3:0] flags_wdata;
        logic trap;
        logic [1:0] cyc;
    } cprt_state_s;

    cprt_state_s s_q, s_d;
    logic cond_pass;
    logic is_xfer, is_und, dir_from, rd_is_pc;

    // Core register field; the select pin, the write address and the PC test all use it.
    function automatic logic [3:0] rd_field(input logic [31:0] w);
        return w[`CPRT_RD_HI:`CPRT_RD_LO]; // [RULE_03]
    endfunction : rd_field

    cprt_cond u_cond (
        .cond(instr[`CPRT_COND_HI:`CPRT_COND_LO]),
        .nzcv(status_flags),
        .pass(cond_pass)
    );

    // Class decode of the incoming word; direction and PC test of the latched word.
    assign is_xfer = (instr[`CPRT_CLASS_HI:`CPRT_CLASS_LO] == `CPRT_CLASS_CRT)
        && instr[`CPRT_XFER_BIT]; // [RULE_02]
    assign is_und = (instr[`CPRT_CLASS_UND_HI:`CPRT_CLASS_UND_LO] == `CPRT_CLASS_UND)
        && instr[`CPRT_UND_BIT];
    assign dir_from = s_q.ins[`CPRT_DIR_BIT]; // [RULE_04]
    assign rd_is_pc = rd_field(s_q.ins) == `CPRT_PC_REG;

    // Next-state logic. The coprocessors run on this same clock and answer in the
    // same cycle as the offer, so their handshake lines are read directly: a
    // two-stage synchroniser would have the core judge a stale answer and add
    // cycles that the transfer timing does not allow.
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.xfer = 1'b0;
        s_d.reg_we = 1'b0;
        s_d.flags_we = 1'b0;
        s_d.trap = 1'b0;
        case (s_q.st)
            CPRT_IDLE: begin
                // Requests are taken only here, so instr_valid is ignored while busy.
                s_d.cyc = CPRT_CY_NONE;
                s_d.busy = 1'b0;
                if (instr_valid && cond_pass && (is_xfer || is_und)) begin // [RULE_01]
                    s_d.ins = instr;
                    s_d.pc = instr_addr;
                    s_d.busy = 1'b1;
                    s_d.req = 1'b1; // Offered to coprocessors in both cases. [RULE_12]
                    s_d.cyc = CPRT_CY_S;
                    s_d.cnt = 2'h0;
                    s_d.st = is_xfer ? CPRT_BUSY : CPRT_UND_S;
                end else if (instr_valid) begin
                    s_d.done = 1'b1; // Failed condition retires with no effect.
                end
            end

            CPRT_BUSY: begin
                // The answer to the offer is judged at the end of the S cycle and
                // again at the end of every busy-wait cycle that follows it.
                if (coproc_not_present && coproc_wait) begin
                    s_d.req = 1'b0; // Nobody claimed it. [RULE_14]
                    s_d.cyc = CPRT_CY_S;
                    s_d.cnt = 2'h1; // The S cycle of the offer counts as the first.
                    s_d.st = CPRT_UND_S;
                end else if (coproc_wait) begin
                    s_d.cyc = CPRT_CY_I; // Busy-wait cycles. [RULE_08] [RULE_09]
                end else if (dir_from) begin
                    s_d.cyc = CPRT_CY_I; // Extra internal cycle. [RULE_08]
                    s_d.st = CPRT_INT;
                end else begin
                    s_d.cyc = CPRT_CY_C;
                    s_d.xfer = 1'b1;
                    s_d.wdata = rd_is_pc ? s_q.pc + `CPRT_PC_OFFSET : core_reg_data; // [RULE_07]
                    s_d.st = CPRT_XFER; // [RULE_09]
                end
            end

            CPRT_INT: begin
                // The extra internal cycle gives the coprocessor time to drive its word.
                s_d.cyc = CPRT_CY_C;
                s_d.xfer = 1'b1;
                s_d.st = CPRT_XFER; // [RULE_08]
            end

            CPRT_XFER: begin
                // One whole word moves in the C cycle. [RULE_10]
                if (dir_from && rd_is_pc) begin
                    s_d.flags_we = 1'b1;
                    s_d.flags_wdata = coproc_rdata[`CPRT_FLAG_HI:`CPRT_FLAG_LO]; // [RULE_06]
                end else if (dir_from) begin
                    s_d.reg_we = 1'b1;
                    s_d.reg_wdata = coproc_rdata;
                end
                s_d.req = 1'b0;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.cyc = CPRT_CY_NONE;
                s_d.st = CPRT_IDLE;
            end

            CPRT_UND_S: begin
                // Two S cycles are counted before the internal one.
                if (s_q.cnt == `CPRT_UND_S_CYCLES - 2'h1) begin
                    s_d.cyc = CPRT_CY_I; // [RULE_13]
                    s_d.st = CPRT_UND_I;
                end else begin
                    s_d.cnt = s_q.cnt + 2'h1;
                    s_d.cyc = CPRT_CY_S;
                end
            end

            CPRT_UND_I: begin
                s_d.req = 1'b0;
                s_d.cyc = CPRT_CY_NONE; // N cycle is marked by the trap pulse.
                s_d.trap = 1'b1; // [RULE_11]
                s_d.st = CPRT_UND_N;
            end

            CPRT_UND_N: begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.cyc = CPRT_CY_NONE;
                s_d.st = CPRT_IDLE;
            end

            default: s_d.st = CPRT_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register; retirement status first.
    assign busy = s_q.busy;
    assign done = s_q.done;

    // Handshake side; the latched word stands until the next instruction is taken.
    assign core_reg_sel = rd_field(s_q.ins); // [RULE_03]
    assign coproc_req = s_q.req;
    assign coproc_number_field = s_q.ins[`CPRT_CPN_HI:`CPRT_CPN_LO]; // [RULE_03]
    assign coproc_instr = s_q.ins; // Fields passed whole to the coprocessor. [RULE_05]
    assign coproc_xfer = s_q.xfer;
    assign coproc_wdata = s_q.wdata;

    // Write-back to the core register file or to the flags.
    assign reg_we = s_q.reg_we;
    assign reg_waddr = rd_field(s_q.ins);
    assign reg_wdata = s_q.reg_wdata;
    assign flags_we = s_q.flags_we;
    assign flags_wdata = s_q.flags_wdata;

    // Trap pulse and the cycle class reported to the rest of the core.
    assign undef_trap = s_q.trap;
    assign cycle_type = s_q.cyc;
endmodule : cprt_unit

// ### dv/cprt_unit_sva.sv
// Port checker for the coprocessor register transfer unit.
`timescale 1ns/1ps
module cprt_unit_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic busy,
    input wire logic done,
    input wire logic coproc_req,
    input wire logic coproc_xfer,
    input wire logic reg_we,
    input wire logic flags_we,
    input wire logic undef_trap,
    input wire logic [1:0] cycle_type
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Undefined handling runs S, S, I, then trap and retirement.
    sequence s_und_run;
        cycle_type == 2'h1 ##1 cycle_type == 2'h1 ##1 cycle_type == 2'h2 ##1 undef_trap ##1 done;
    endsequence
    a_undef_steps: assert property (instr_valid && !busy && instr[31:25] == 7'h73
        && instr[4] |=> s_und_run) else $error("undef order");
    a_xfer_start: assert property (instr_valid && !busy && instr[31:24] == 8'hEE
        && instr[4] |=> busy && coproc_req && cycle_type == 2'h1) else $error("no start");
    a_fail_quiet: assert property (instr_valid && !busy && instr[31:28] == 4'hF
        |=> done && !coproc_req) else $error("fail not retired");
    a_xfer_retire: assert property (coproc_xfer |-> cycle_type == 2'h3 ##1 done)
        else $error("late done");
    a_xfer_single: assert property (coproc_xfer |=> !coproc_xfer)
        else $error("two words");
    a_write_done: assert property (reg_we || flags_we |-> done && !(reg_we && flags_we))
        else $error("stray write");
    a_trap_done: assert property (undef_trap |-> !coproc_xfer ##1 done)
        else $error("trap not retired");
    a_busy_bound: assert property ($rose(busy) |-> ##[1:60] done)
        else $error("hung");
endmodule : cprt_unit_sva

// ### dv/cprt_cp_model.sv
// Model coprocessor number 5 with a settable stall.
`timescale 1ns/1ps
module cprt_cp_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic coproc_req,
    input wire logic [3:0] coproc_number_field,
    input wire logic [31:0] coproc_instr,
    input wire logic coproc_xfer,
    input wire logic [3:0] wait_n,
    input wire logic [31:0] rd_word,
    output logic coproc_not_present,
    output logic coproc_wait,
    output logic [31:0] coproc_rdata
);
    logic [3:0] left_q;
    // Other numbers and the undefined class are refused with both lines high.
    assign coproc_not_present = coproc_req &&
        (coproc_instr[27:25] == 3'h3 || coproc_number_field != 4'h5);
    assign coproc_wait = coproc_not_present || (coproc_req && left_q != 4'h0);
    // Off the transfer cycle the word is inverted, so a late sample cannot match.
    assign coproc_rdata = coproc_xfer ? rd_word : ~rd_word;
    // The stall count reloads between requests.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            left_q <= 4'h0;
        end else begin
            left_q <= coproc_req ? left_q - {3'h0, left_q != 4'h0} : wait_n;
        end
    end
endmodule : cprt_cp_model

// ### dv/tb.sv
// Bench for the coprocessor register transfer unit.
`timescale 1ns/1ps
module tb;
    logic sys_clk, rst, instr_valid, coproc_not_present, coproc_wait, busy, done;
    logic coproc_req, coproc_xfer, reg_we, flags_we, undef_trap;
    logic [31:0] instr, instr_addr, core_reg_data, coproc_rdata, coproc_instr, coproc_wdata;
    logic [31:0] reg_wdata, rd_word, xw;
    logic [3:0] status_flags, core_reg_sel, coproc_number_field, reg_waddr, flags_wdata;
    logic [3:0] wait_n, fl;
    logic [1:0] cycle_type;
    logic [35:0] wr;
    int n_fail, n_checks, ns, ni, nc, nt, seen, i_to;
    cprt_unit u_dut (
        .sys_clk, .rst, .instr_valid, .instr, .instr_addr, .core_reg_data, .status_flags,
        .coproc_not_present, .coproc_wait, .coproc_rdata, .busy, .done, .core_reg_sel,
        .coproc_req, .coproc_number_field, .coproc_instr, .coproc_xfer, .coproc_wdata,
        .reg_we, .reg_waddr, .reg_wdata, .flags_we, .flags_wdata, .undef_trap, .cycle_type
    );
    cprt_cp_model u_cp (
        .sys_clk, .rst, .coproc_req, .coproc_number_field, .coproc_instr, .coproc_xfer,
        .wait_n, .rd_word, .coproc_not_present, .coproc_wait, .coproc_rdata
    );
    // A 20 ns clock.
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Outputs are tallied at the falling edge, once settled.
    always @(negedge sys_clk) begin
        ns += (cycle_type === 2'h1);
        ni += (cycle_type === 2'h2);
        nc += (cycle_type === 2'h3);
        nt += (undef_trap === 1'b1);
        seen += (done === 1'b1);
        if (coproc_xfer === 1'b1) xw = coproc_wdata;
        if (reg_we === 1'b1) wr = {reg_waddr, reg_wdata};
        if (flags_we === 1'b1) fl = flags_wdata;
    end
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask : chk
    function automatic logic [31:0] mk(logic [3:0] c, logic l, logic [3:0] r, logic [3:0] p);
        return {c, 4'hE, 3'h2, l, 4'h6, r, p, 8'h37};
    endfunction : mk
    // One instruction; d is address, core word and read word alike, f holds flags and stall.
    task automatic run(input logic [31:0] i, input logic [31:0] d, input logic [7:0] f);
        @(posedge sys_clk);
        {ns, ni, nc, nt, seen, xw, wr, fl} = '0;
        {status_flags, wait_n, instr, instr_addr, core_reg_data, rd_word} <= {f, i, d, d, d};
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        for (int k = 0; k < 99 && seen == 0; k++) @(negedge sys_clk);
        chk(seen == 1, "done");
    endtask : run
    // Move-to from a register and from the program counter; no busy-wait means no I cycle.
    task automatic t_move_to();
        run(mk(4'hE, 1'b0, 4'h3, 4'h5), 32'hA5C3_0F96, 8'h0);
        chk(xw === 32'hA5C3_0F96 && wr === 36'h0, "to");
        chk(ns == 1 && ni == 0 && nc == 1, "to cycles");
        chk(coproc_instr === mk(4'hE, 1'b0, 4'h3, 4'h5), "word");
        chk(coproc_number_field === 4'h5 && core_reg_sel === 4'h3, "fields");
        run(mk(4'hE, 1'b0, 4'hF, 4'h5), 32'h0000_0104, 8'h0);
        chk(xw === 32'h0000_0110, "pc");
    endtask : t_move_to
    // Move-from to a register and to the flags, then three busy-wait cycles each way.
    task automatic t_move_from();
        run(mk(4'hE, 1'b1, 4'h7, 4'h5), 32'h1234_5678, 8'h0);
        chk(wr === 36'h7_1234_5678 && fl === 4'h0, "from");
        chk(ns == 1 && ni == 1 && nc == 1, "from cycles");
        run(mk(4'hE, 1'b1, 4'hF, 4'h5), 32'hA000_0001, 8'h0);
        chk(fl === 4'hA && wr === 36'h0, "flags");
        run(mk(4'hE, 1'b0, 4'h2, 4'h5), 32'h0, 8'h3);
        i_to = ni;
        chk(ni == 3 && nc == 1, "stall to");
        run(mk(4'hE, 1'b1, 4'h2, 4'h5), 32'h0, 8'h3);
        chk(ni == i_to + 1 && nc == 1, "stall from");
    endtask : t_move_from
    // Failing conditions retire quietly, a passing one transfers; refusals trap.
    task automatic t_cond_undef();
        run(mk(4'h0, 1'b0, 4'h1, 4'h5), 32'h0, 8'h0);
        chk(ns + nc + nt == 0, "eq");
        run(mk(4'h0, 1'b0, 4'h1, 4'h5), 32'h0000_5A5A, 8'h40);
        chk(xw === 32'h0000_5A5A && nc == 1, "eq taken");
        run(mk(4'hF, 1'b0, 4'h1, 4'h5), 32'h0, 8'h40);
        chk(ns + nc + nt == 0, "nv");
        run(32'hE600_0010, 32'h0, 8'h0);
        chk(nt == 1 && ns == 2 && ni == 1 && nc == 0, "undef");
        run(mk(4'hE, 1'b0, 4'h1, 4'h9), 32'h0, 8'h0);
        chk(nt == 1 && nc == 0 && xw === 32'h0, "absent");
    endtask : t_cond_undef
    // Inputs start defined; reset spans four clocks.
    initial begin
        {rst, instr_valid, instr, instr_addr, core_reg_data, rd_word} = {2'h2, 128'h0};
        {status_flags, wait_n} = 8'h0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_move_to();
        t_move_from();
        t_cond_undef();
        tally_and_finish();
    end
    // The tests need little over a microsecond; the watchdog allows far more.
    initial begin
        #50us;
        n_fail++;
        $display("mismatch %0t watchdog expired", $time);
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
endmodule : tb
bind cprt_unit cprt_unit_sva u_sva (.sys_clk, .rst, .instr_valid, .instr, .busy, .done,
    .coproc_req, .coproc_xfer, .reg_we, .flags_we, .undef_trap, .cycle_type);
